// >>> logic/mem_map_decoder.sv
// Memory-map decoder: code region translation, flash access policy,
// internal RAM with register banks, bit area and stack, and auxiliary RAM.
// Assumes the execution core shares CORE_CLK and RST_N and waits on CALL_BUSY.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mem_map_decoder #(
	parameter int XBYTES = mem_map_pkg::AUXILIARY_RAM_BYTES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// Boot strap pin
	input wire logic BOOT_LOADER,
	// Code fetch and code-memory read
	input wire logic CODE_REQ,
	input wire logic [15:0] CODE_PC,
	output logic [14:0] FETCH_ADDR,
	output logic FETCH_VALID,
	output logic FETCH_FAULT,
	// Interrupt accept
	input wire logic INT_ACK,
	input wire logic [4:0] INT_NUM,
	output logic [15:0] VEC_PC,
	// Flash operation policy
	input wire mem_map_pkg::flash_req_t FL_IN,
	output logic FL_GRANT,
	output logic FL_DENY,
	output logic [7:0] FL_PAGE,
	// Internal data access
	input wire mem_map_pkg::data_req_t DM_IN,
	input wire logic [1:0] PSW_BANK,
	output logic [7:0] DM_RDATA,
	output logic SFR_SEL,
	output logic [7:0] SFR_ADDR,
	output logic SFR_BIT_OK,
	// Stack
	input wire logic STK_PUSH,
	input wire logic STK_POP,
	input wire logic [7:0] STK_WDATA,
	input wire logic CALL_REQ,
	input wire logic [15:0] RET_PC,
	output logic [7:0] STK_RDATA,
	output logic CALL_BUSY,
	// Auxiliary RAM
	input wire logic XR_REQ,
	input wire logic XR_WR,
	input wire logic [15:0] XR_ADDR,
	input wire logic [7:0] XR_WDATA,
	output logic [7:0] XR_RDATA
);

	typedef struct packed {
		mem_map_pkg::stack_state_t fsm;
		logic [7:0] cfg;
		logic [7:0] sp;
		logic boot_s1;
		logic boot_s2;
		logic started;
		logic in_loader;
		logic [7:0] ret_hi;
		logic [14:0] fetch_addr;
		logic fetch_vld;
		logic fetch_flt;
		logic [15:0] vec_pc;
		logic [7:0] dm_rdata;
		logic [7:0] stk_rdata;
		logic [7:0] xr_rdata;
		logic [7:0] reg_rdata;
		logic fl_grant;
		logic fl_deny;
		logic [7:0] fl_page;
		logic [255:0][7:0] iram;
		logic [XBYTES-1:0][7:0] auxiliary_ram;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Loader size in kilobytes from the size field
	function automatic logic [2:0] loader_kb(input logic [2:0] sel);
		case (sel)
			3'b111: loader_kb = 3'd0;
			3'b110: loader_kb = 3'd1;
			3'b101: loader_kb = 3'd2;
			3'b100: loader_kb = 3'd3;
			default: loader_kb = 3'd4;
		endcase
	endfunction : loader_kb

	// Byte that holds a bit address
	function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
		bit_byte = baddr[7] ? {baddr[7:3], 3'b000} : 8'(mem_map_pkg::BIT_AREA_BASE + baddr[6:3]);
	endfunction : bit_byte

	logic [2:0] ld_kb;
	logic [14:0] ld_bytes;
	logic [14:0] app_bytes;
	assign ld_kb = loader_kb(s_q.cfg[mem_map_pkg::SIZE_LSB +: mem_map_pkg::SIZE_W]);
	assign ld_bytes = 15'(int'(ld_kb) * mem_map_pkg::KBYTE);
	assign app_bytes = 15'(mem_map_pkg::FLASH_BYTES - int'(ld_bytes));

	// the captured strap counts only while a loader region exists
	logic in_ldr;
	assign in_ldr = s_q.in_loader && (ld_kb != 3'd0);

	logic [15:0] vec_calc;
	assign vec_calc = 16'(mem_map_pkg::VEC_FIRST + (16'(INT_NUM) << mem_map_pkg::VEC_SHIFT));

	// Code address seen by the flash: vector on accept, else the program counter
	logic [15:0] code_pc;
	assign code_pc = INT_ACK ? vec_calc : CODE_PC;

	// Internal data byte address for the current request
	// bank registers follow the status-word bank bits
	logic [7:0] dm_byte;
	logic dm_sfr;
	always_comb begin
		if (DM_IN.bank_reg) begin
			dm_byte = {3'b000, PSW_BANK, DM_IN.addr[2:0]};
		end else if (DM_IN.bit_op) begin
			dm_byte = bit_byte(DM_IN.addr);
		end else begin
			dm_byte = DM_IN.addr;
		end
	end
	// indirect above 7FH reaches upper RAM, direct reaches registers
	assign dm_sfr = DM_IN.req && !DM_IN.indirect && !DM_IN.bank_reg && dm_byte[7];

	// register space is direct-only; bit access only on x0H/x8H
	assign SFR_SEL = dm_sfr && (dm_byte != mem_map_pkg::SP_REG_ADDR);
	assign SFR_ADDR = dm_sfr ? dm_byte : 8'h00;
	assign SFR_BIT_OK = dm_sfr && DM_IN.bit_op && (dm_byte[2:0] == 3'b000);

	// Auxiliary address within the populated range
	logic xr_hit;
	assign xr_hit = XR_REQ && (XR_ADDR <= mem_map_pkg::AUXILIARY_RAM_TOP) && (int'(XR_ADDR) < XBYTES);

	logic [7:0] sp_inc;
	logic [7:0] sp_dec;
	logic [7:0] top_byte;
	assign sp_inc = 8'(s_q.sp + 8'h01);
	assign sp_dec = 8'(s_q.sp - 8'h01);
	assign top_byte = s_q.iram[s_q.sp];

	// Next-state logic for the whole block
	always_comb begin
		logic [14:0] base;
		logic [14:0] limit;
		logic [7:0] cur;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic fl_ok;
		s_d = s_q;
		base = 15'h0000;
		limit = app_bytes;
		cur = s_q.iram[dm_byte];
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		fl_ok = 1'b0;
		s_d.fetch_vld = 1'b0;
		s_d.fl_grant = 1'b0;
		s_d.fl_deny = 1'b0;

		// Strap synchroniser; the boot region is caught once after release
		s_d.boot_s1 = BOOT_LOADER;
		s_d.boot_s2 = s_q.boot_s1;
		s_d.started = 1'b1;
		// strap caught once; the size field is applied live, so a later write still counts
		if (!s_q.started) begin
			s_d.in_loader = s_q.boot_s2;
		end

		// loader code sits after the application region
		if (in_ldr) begin
			base = app_bytes;
			limit = ld_bytes;
		end
		// fetch translates from the active region; code reads too
		if (CODE_REQ || INT_ACK) begin
			s_d.fetch_vld = 1'b1;
			s_d.fetch_flt = (int'(code_pc) >= int'(limit));
			s_d.fetch_addr = 15'(base + code_pc[14:0]);
		end
		if (INT_ACK) begin
			s_d.vec_pc = vec_calc;
		end

		// reads always allowed; erase and program checked
		// each region may rewrite the other
		if (FL_IN.req) begin
			if (FL_IN.ext_tool || FL_IN.op == mem_map_pkg::FL_READ) begin
				fl_ok = 1'b1;
			end else if (in_ldr) begin
				fl_ok = (FL_IN.region != mem_map_pkg::RG_LOADER);
			end else begin
				fl_ok = (FL_IN.region == mem_map_pkg::RG_LOADER);
			end
			s_d.fl_grant = fl_ok;
			s_d.fl_deny = !fl_ok;
			s_d.fl_page = 8'(FL_IN.addr >> mem_map_pkg::PAGE_SHIFT);
		end

		// Internal data access: reads always answer next cycle
		if (DM_IN.req) begin
			if (dm_sfr) begin
				s_d.dm_rdata = (dm_byte == mem_map_pkg::SP_REG_ADDR) ? s_q.sp : 8'h00;
			end else if (DM_IN.bit_op) begin
				// bit area picks one bit of its byte
				s_d.dm_rdata = {7'b0000000, cur[DM_IN.addr[2:0]]};
			end else begin
				s_d.dm_rdata = cur;
			end
			if (DM_IN.wr && !dm_sfr) begin
				wr_en = 1'b1;
				wr_addr = dm_byte;
				wr_data = DM_IN.wdata;
				if (DM_IN.bit_op) begin
					wr_data = cur;
					wr_data[DM_IN.addr[2:0]] = DM_IN.wdata[0];
				end
			end
			// software loads the stack pointer directly
			if (DM_IN.wr && dm_sfr && dm_byte == mem_map_pkg::SP_REG_ADDR) begin
				s_d.sp = DM_IN.wdata;
			end
		end

		// Stack sequencer; a stack write takes the RAM port over a data write
		case (s_q.fsm)
			mem_map_pkg::ST_IDLE: begin
				// calls and accepted interrupts save the return address
				if (CALL_REQ || INT_ACK) begin
					wr_en = 1'b1;
					wr_addr = sp_inc;
					wr_data = RET_PC[7:0];
					s_d.sp = sp_inc;
					s_d.ret_hi = RET_PC[15:8];
					s_d.fsm = mem_map_pkg::ST_CALL_HI;
				end else if (STK_PUSH) begin
					wr_en = 1'b1;
					wr_addr = sp_inc;
					wr_data = STK_WDATA;
					s_d.sp = sp_inc;
				end else if (STK_POP) begin
					s_d.stk_rdata = top_byte;
					s_d.sp = sp_dec;
				end
			end
			mem_map_pkg::ST_CALL_HI: begin
				wr_en = 1'b1;
				wr_addr = sp_inc;
				wr_data = s_q.ret_hi;
				s_d.sp = sp_inc;
				s_d.fsm = mem_map_pkg::ST_IDLE;
			end
			default: begin
				s_d.fsm = mem_map_pkg::ST_IDLE;
			end
		endcase
		// stack and data writes land only in internal RAM
		if (wr_en) begin
			s_d.iram[wr_addr] = wr_data;
		end

		// auxiliary RAM by external move only; beyond top ignored
		if (XR_REQ) begin
			s_d.xr_rdata = 8'h00;
			if (xr_hit) begin
				s_d.xr_rdata = s_q.auxiliary_ram[XR_ADDR[9:0]];
				if (XR_WR) begin
					s_d.auxiliary_ram[XR_ADDR[9:0]] = XR_WDATA;
				end
			end
		end

		// Register port; upper config bits are fixed ones
		if (REG_WR && REG_ADDR == mem_map_pkg::REG_BOOT_CFG) begin
			s_d.cfg[mem_map_pkg::SIZE_LSB +: mem_map_pkg::SIZE_W] = REG_WDATA[2:0];
		end
		if (REG_RD) begin
			case (REG_ADDR)
				mem_map_pkg::REG_BOOT_CFG: s_d.reg_rdata = s_q.cfg;
				mem_map_pkg::REG_STATUS: s_d.reg_rdata = {4'h0, in_ldr, ld_kb};
				mem_map_pkg::REG_STACK: s_d.reg_rdata = s_q.sp;
				default: s_d.reg_rdata = 8'h00;
			endcase
		end
	end

	// State register; RAM contents are cleared too so reads are defined
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.fsm <= mem_map_pkg::ST_IDLE;
			s_q.cfg <= mem_map_pkg::BOOT_CFG_RESET;
			// Strap flops keep sampling through reset so the strap is settled at release
			s_q.boot_s1 <= s_d.boot_s1;
			s_q.boot_s2 <= s_d.boot_s2;
			s_q.sp <= mem_map_pkg::SP_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign REG_RDATA = s_q.reg_rdata;
	assign FETCH_ADDR = s_q.fetch_addr;
	assign FETCH_VALID = s_q.fetch_vld;
	assign FETCH_FAULT = s_q.fetch_flt;
	assign VEC_PC = s_q.vec_pc;
	assign FL_GRANT = s_q.fl_grant;
	assign FL_DENY = s_q.fl_deny;
	assign FL_PAGE = s_q.fl_page;
	assign DM_RDATA = s_q.dm_rdata;
	assign STK_RDATA = s_q.stk_rdata;
	assign CALL_BUSY = (s_q.fsm == mem_map_pkg::ST_CALL_HI);
	assign XR_RDATA = s_q.xr_rdata;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	property p_sp_reset;
		!$past(RST_N) |-> s_q.sp == mem_map_pkg::SP_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not 07H after reset");

	property p_fetch_zero;
		CODE_REQ && !INT_ACK && CODE_PC == 16'h0000 |=>
			FETCH_VALID && FETCH_ADDR == ($past(in_ldr) ? $past(app_bytes) : 15'h0000);
	endproperty
	a_fetch_zero: assert property (p_fetch_zero) else $error("code zero misplaced");

	property p_vector;
		INT_ACK && INT_NUM == 5'd1 |=> VEC_PC == 16'h000B;
	endproperty
	a_vector: assert property (p_vector) else $error("timer vector wrong");

	property p_split;
		s_q.cfg[2:0] == 3'b110 |-> app_bytes == 15'd17408;
	endproperty
	a_split: assert property (p_split) else $error("region split wrong");

	property p_dir_ind;
		DM_IN.req && !DM_IN.bank_reg && !DM_IN.bit_op && DM_IN.addr[7] |-> dm_sfr != DM_IN.indirect;
	endproperty
	a_dir_ind: assert property (p_dir_ind) else $error("upper space decode wrong");

	property p_bit_sfr;
		SFR_BIT_OK |-> SFR_ADDR[2:0] == 3'b000 && SFR_ADDR[7];
	endproperty
	a_bit_sfr: assert property (p_bit_sfr) else $error("bit access on byte-only register");

	property p_bank;
		DM_IN.req && DM_IN.bank_reg |-> dm_byte == {3'b000, PSW_BANK, DM_IN.addr[2:0]};
	endproperty
	a_bank: assert property (p_bank) else $error("bank address wrong");

	property p_bit_area;
		DM_IN.req && DM_IN.bit_op && !DM_IN.addr[7] |-> dm_byte inside {[8'h20:8'h2F]};
	endproperty
	a_bit_area: assert property (p_bit_area) else $error("bit area outside 20H-2FH");

	property p_push;
		s_q.fsm == mem_map_pkg::ST_IDLE && STK_PUSH && !CALL_REQ && !INT_ACK |=>
			s_q.sp == 8'($past(s_q.sp) + 8'h01) && top_byte == $past(STK_WDATA);
	endproperty
	a_push: assert property (p_push) else $error("push order wrong");

	property p_pop;
		s_q.fsm == mem_map_pkg::ST_IDLE && STK_POP && !STK_PUSH && !CALL_REQ && !INT_ACK
			&& !(DM_IN.req && DM_IN.wr) |=>
			STK_RDATA == $past(top_byte) && s_q.sp == 8'($past(s_q.sp) - 8'h01);
	endproperty
	a_pop: assert property (p_pop) else $error("pop order wrong");

	property p_call;
		s_q.fsm == mem_map_pkg::ST_IDLE && CALL_REQ |=> CALL_BUSY ##1
			(!CALL_BUSY && s_q.sp == 8'($past(s_q.sp, 2) + 8'h02) && top_byte == $past(RET_PC[15:8], 2));
	endproperty
	a_call: assert property (p_call) else $error("return address not stacked");

	property p_xr_top;
		XR_REQ && XR_ADDR > 16'h02FF |=> XR_RDATA == 8'h00 && $stable(s_q.auxiliary_ram);
	endproperty
	a_xr_top: assert property (p_xr_top) else $error("unmapped auxiliary access took effect");

	property p_stack_not_aux;
		STK_PUSH && !XR_REQ |=> $stable(s_q.auxiliary_ram);
	endproperty
	a_stack_not_aux: assert property (p_stack_not_aux) else $error("stack touched auxiliary RAM");

	property p_policy;
		FL_IN.req && !FL_IN.ext_tool && FL_IN.op != mem_map_pkg::FL_READ && !in_ldr
			&& FL_IN.region == mem_map_pkg::RG_APP |=> FL_DENY && !FL_GRANT;
	endproperty
	a_policy: assert property (p_policy) else $error("application rewrote itself");

	c_loader_fetch: cover property (in_ldr && CODE_REQ ##1 FETCH_VALID);
	c_int_call: cover property (INT_ACK && s_q.fsm == mem_map_pkg::ST_IDLE ##2 !CALL_BUSY);
	c_push_pop: cover property (STK_PUSH ##1 STK_POP);
	c_xr_write: cover property (XR_REQ && XR_WR && xr_hit);

endmodule : mem_map_decoder
`default_nettype wire

// >>> shared/mem_map_pkg.sv
// Constants and types for the memory-map decoder of the small 8-bit core.
// Assumes one clock and one synchronous active-low reset shared with the core.
package mem_map_pkg;

	// Register port offsets
	localparam logic [3:0] REG_BOOT_CFG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_STACK = 4'h2;
	localparam logic [7:0] BOOT_CFG_RESET = 8'hFF;
	localparam int SIZE_LSB = 0;
	localparam int SIZE_W = 3;

	// Flash geometry
	localparam int FLASH_BYTES = 18432;
	localparam int KBYTE = 1024;
	localparam int PAGE_BYTES = 128;
	localparam int PAGE_SHIFT = 7;
	localparam int FADDR_W = 15;

	// Code vectors
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] VEC_FIRST = 16'h0003;
	localparam int VEC_SHIFT = 3;

	// Internal data space
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] SP_REG_ADDR = 8'h81;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam int AUXILIARY_RAM_BYTES = 768;
	localparam logic [15:0] AUXILIARY_RAM_TOP = 16'h02FF;

	// Flash operations and regions
	typedef enum logic [1:0] {FL_READ = 2'b00, FL_ERASE = 2'b01, FL_PROGRAM = 2'b10} flash_op_t;
	typedef enum logic [1:0] {RG_APP = 2'b00, RG_LOADER = 2'b01, RG_CONFIG = 2'b10} flash_region_t;

	// Stack sequencer states
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CALL_HI = 2'b10} stack_state_t;

	// Internal data request from the core
	typedef struct packed {
		logic req;
		logic wr;
		logic indirect;
		logic bit_op;
		logic bank_reg;
		logic [7:0] addr;
		logic [7:0] wdata;
	} data_req_t;

	// Flash operation request
	typedef struct packed {
		logic req;
		logic ext_tool;
		flash_op_t op;
		flash_region_t region;
		logic [FADDR_W-1:0] addr;
	} flash_req_t;

endpackage : mem_map_pkg

// >>> tb/cpu_memory_map_decoder_bench.sv
// Self-checking bench for the memory-map decoder with a modelled core.
// Assumes the decoder answers each request one cycle later, register-space decode in the same cycle, with one CALL_BUSY stall after a call or interrupt.
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_map_decoder_bench;
	logic core_clk, rst_n, boot_loader, rg_wr, rg_rd, code_req, fetch_valid, fetch_fault;
	logic int_ack, fl_grant, fl_deny, sfr_sel, sfr_ok, stk_push, stk_pop, call_req;
	logic call_busy, xr_req, xr_wr;
	logic [3:0] rg_addr;
	logic [4:0] int_num;
	logic [1:0] psw_bank;
	logic [7:0] rg_wdata, rg_rdata, fl_page, dm_rdata, sfr_addr, stk_wdata, stk_rdata;
	logic [7:0] xr_wdata, xr_rdata, v;
	logic [14:0] fetch_addr;
	logic [15:0] code_pc, vec_pc, ret_pc, xr_addr, app;
	mem_map_pkg::flash_req_t fl_in;
	mem_map_pkg::data_req_t dm_in;
	int miscompares = 0;
	int cmp_count = 0;
	logic [2:0] sz [6] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h0};
	int kbs [6] = '{0, 1, 2, 3, 4, 4};

	mem_map_decoder dut_u (.CORE_CLK(core_clk), .RST_N(rst_n), .REG_ADDR(rg_addr),
		.REG_WDATA(rg_wdata), .REG_WR(rg_wr), .REG_RD(rg_rd), .REG_RDATA(rg_rdata),
		.BOOT_LOADER(boot_loader), .CODE_REQ(code_req), .CODE_PC(code_pc),
		.FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid), .FETCH_FAULT(fetch_fault),
		.INT_ACK(int_ack), .INT_NUM(int_num), .VEC_PC(vec_pc), .FL_IN(fl_in),
		.FL_GRANT(fl_grant), .FL_DENY(fl_deny), .FL_PAGE(fl_page), .DM_IN(dm_in),
		.PSW_BANK(psw_bank), .DM_RDATA(dm_rdata), .SFR_SEL(sfr_sel), .SFR_ADDR(sfr_addr),
		.SFR_BIT_OK(sfr_ok), .STK_PUSH(stk_push), .STK_POP(stk_pop), .STK_WDATA(stk_wdata),
		.CALL_REQ(call_req), .RET_PC(ret_pc), .STK_RDATA(stk_rdata), .CALL_BUSY(call_busy),
		.XR_REQ(xr_req), .XR_WR(xr_wr), .XR_ADDR(xr_addr), .XR_WDATA(xr_wdata),
		.XR_RDATA(xr_rdata));

	exec_core_model core_u (.clk(core_clk), .busy(call_busy), .sfr_sel(sfr_sel),
		.sfr_ok(sfr_ok), .sfr_addr(sfr_addr), .code_req(code_req), .code_pc(code_pc),
		.int_ack(int_ack), .int_num(int_num), .ret_pc(ret_pc), .call_req(call_req),
		.fl_in(fl_in), .dm_in(dm_in), .psw_bank(psw_bank), .stk_push(stk_push),
		.stk_pop(stk_pop), .stk_wdata(stk_wdata), .xr_req(xr_req), .xr_wr(xr_wr),
		.xr_addr(xr_addr), .xr_wdata(xr_wdata));

	// Free-running 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Value compare with mismatch report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Reset with the strap held steady well before release
	task automatic do_reset(input logic bl);
		boot_loader <= bl;
		rst_n <= 1'b0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask : do_reset

	// Register port write and read
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{rg_wr, rg_addr, rg_wdata} <= {1'b1, a, d};
		@(posedge core_clk);
		rg_wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		{rg_rd, rg_addr} <= {1'b1, a};
		@(posedge core_clk);
		rg_rd <= 1'b0;
		#1 d = rg_rdata;
	endtask : rd_reg

	// Flash request against the policy, one fixed address
	task automatic flchk(input logic t, input mem_map_pkg::flash_op_t o,
		input mem_map_pkg::flash_region_t r, input logic g);
		core_u.fl(t, o, r, 15'h1234);
		#1 chk({fl_grant, fl_deny}, {g, ~g});
		chk(fl_page, 8'h24);
	endtask : flchk

	// Watchdog: the whole sequence needs about two hundred cycles
	initial begin
		#200us;
		miscompares++;
		tally_and_finish();
	end

	initial begin
		{rst_n, boot_loader, rg_wr, rg_rd, rg_addr, rg_wdata} = '0;
		do_reset(1'b0);
		rd_reg(4'h0, v); chk(v, 8'hFF);
		rd_reg(4'h2, v); chk(v, 8'h07);
		rd_reg(4'h3, v); chk(v, 8'h00);
		core_u.fetch(16'h0000);
		#1 chk({fetch_valid, fetch_fault, fetch_addr}, 17'h1_0000);
		// Every loader size, fault exactly at the region end
		for (int i = 0; i < 6; i++) begin
			app = 16'(mem_map_pkg::FLASH_BYTES - kbs[i] * mem_map_pkg::KBYTE);
			wr_reg(4'h0, {5'h00, sz[i]});
			rd_reg(4'h0, v); chk(v, {5'h1F, sz[i]});
			rd_reg(4'h1, v); chk(v, 8'(kbs[i]));
			core_u.fetch(app - 16'h0001);
			#1 chk({fetch_fault, fetch_addr}, {1'b0, 15'(app - 16'h0001)});
			core_u.fetch(app);
			#1 chk(fetch_fault, 1'b1);
		end
		// Interrupts vector and stack the return address
		for (int n = 0; n < 3; n++) begin
			core_u.call(1'b1, 5'(n), 16'(16'h0100 + n));
			#1 chk(vec_pc, 16'(16'h0003 + 8 * n));
			chk(fetch_addr, 15'(16'h0003 + 8 * n));
			chk(core_u.busy_seen, 1'b1);
		end
		rd_reg(4'h2, v); chk(v, 8'h0D);
		core_u.stk(1'b0, 8'h00); #1 chk(stk_rdata, 8'h01);
		core_u.stk(1'b0, 8'h00); #1 chk(stk_rdata, 8'h02);
		rd_reg(4'h2, v); chk(v, 8'h0B);
		core_u.dm(1'b1, 1'b0, 1'b0, 1'b0, 8'h81, 8'h40);
		rd_reg(4'h2, v); chk(v, 8'h40);
		core_u.call(1'b0, 5'h00, 16'h1234);
		core_u.dm(1'b0, 1'b1, 1'b0, 1'b0, 8'h41, 8'h00); #1 chk(dm_rdata, 8'h34);
		core_u.dm(1'b0, 1'b1, 1'b0, 1'b0, 8'h42, 8'h00); #1 chk(dm_rdata, 8'h12);
		core_u.stk(1'b1, 8'h77);
		core_u.stk(1'b0, 8'h00); #1 chk(stk_rdata, 8'h77);
		core_u.xr(1'b0, 16'h0041, 8'h00); #1 chk(xr_rdata, 8'h00);
		// Upper RAM and register space share addresses but not storage
		core_u.dm(1'b1, 1'b1, 1'b0, 1'b0, 8'h90, 8'hA5);
		core_u.dm(1'b1, 1'b0, 1'b0, 1'b0, 8'h90, 8'h3C); chk(core_u.seen[9], 1'b1);
		core_u.dm(1'b0, 1'b1, 1'b0, 1'b0, 8'h90, 8'h00); #1 chk(dm_rdata, 8'hA5);
		chk(core_u.seen[9], 1'b0);
		core_u.dm(1'b1, 1'b0, 1'b0, 1'b0, 8'h30, 8'h66);
		core_u.dm(1'b0, 1'b1, 1'b0, 1'b0, 8'h30, 8'h00); #1 chk(dm_rdata, 8'h66);
		core_u.dm(1'b0, 1'b0, 1'b1, 1'b0, 8'h8A, 8'h00); chk(core_u.seen, 10'h388);
		// Each bank maps register five to its own byte
		for (int b = 0; b < 4; b++) begin
			@(posedge core_clk) core_u.psw_bank <= 2'(b);
			core_u.dm(1'b1, 1'b0, 1'b0, 1'b1, 8'h05, 8'(8'h50 + b));
		end
		for (int b = 0; b < 4; b++) begin
			core_u.dm(1'b0, 1'b0, 1'b0, 1'b0, 8'(8 * b + 5), 8'h00);
			#1 chk(dm_rdata, 8'(8'h50 + b));
		end
		core_u.dm(1'b1, 1'b0, 1'b1, 1'b0, 8'h0F, 8'h01);
		core_u.dm(1'b0, 1'b0, 1'b0, 1'b0, 8'h21, 8'h00); #1 chk(dm_rdata, 8'h80);
		core_u.dm(1'b0, 1'b0, 1'b1, 1'b0, 8'h0F, 8'h00); #1 chk(dm_rdata[0], 1'b1);
		// Auxiliary RAM edges and the unmapped space above it
		core_u.xr(1'b1, 16'h0000, 8'hC3);
		core_u.xr(1'b1, 16'h02FF, 8'h5A);
		core_u.xr(1'b1, 16'h0300, 8'h11);
		core_u.xr(1'b0, 16'h02FF, 8'h00); #1 chk(xr_rdata, 8'h5A);
		core_u.xr(1'b0, 16'h0000, 8'h00); #1 chk(xr_rdata, 8'hC3);
		core_u.xr(1'b0, 16'h0300, 8'h00); #1 chk(xr_rdata, 8'h00);
		flchk(1'b0, mem_map_pkg::FL_READ, mem_map_pkg::RG_APP, 1'b1);
		flchk(1'b0, mem_map_pkg::FL_PROGRAM, mem_map_pkg::RG_LOADER, 1'b1);
		flchk(1'b0, mem_map_pkg::FL_ERASE, mem_map_pkg::RG_APP, 1'b0);
		flchk(1'b0, mem_map_pkg::FL_PROGRAM, mem_map_pkg::RG_CONFIG, 1'b0);
		flchk(1'b1, mem_map_pkg::FL_ERASE, mem_map_pkg::RG_APP, 1'b1);
		// Second reset, booting from the loader region of 4K
		do_reset(1'b1);
		wr_reg(4'h0, 8'h00);
		rd_reg(4'h1, v); chk(v, 8'h0C);
		core_u.fetch(16'h0000); #1 chk(fetch_addr, 15'h3800);
		core_u.fetch(16'h1000); #1 chk(fetch_fault, 1'b1);
		core_u.call(1'b1, 5'h01, 16'h0020); #1 chk(fetch_addr, 15'h380B);
		flchk(1'b0, mem_map_pkg::FL_PROGRAM, mem_map_pkg::RG_APP, 1'b1);
		flchk(1'b0, mem_map_pkg::FL_ERASE, mem_map_pkg::RG_CONFIG, 1'b1);
		flchk(1'b0, mem_map_pkg::FL_PROGRAM, mem_map_pkg::RG_LOADER, 1'b0);
		tally_and_finish();
	end
endmodule : cpu_memory_map_decoder_bench
`default_nettype wire

// >>> tb/exec_core_model.sv
// Behavioural execution core that issues one-cycle requests to the decoder.
// Assumes the bench calls its tasks one at a time, after reset is released.
`timescale 1ns/1ps
`default_nettype none
module exec_core_model (
	// Clock and decoder feedback
	input wire logic clk,
	input wire logic busy,
	input wire logic sfr_sel,
	input wire logic sfr_ok,
	input wire logic [7:0] sfr_addr,
	// Code side
	output logic code_req,
	output logic [15:0] code_pc,
	output logic int_ack,
	output logic [4:0] int_num,
	output logic [15:0] ret_pc,
	output logic call_req,
	// Data side
	output var mem_map_pkg::flash_req_t fl_in,
	output var mem_map_pkg::data_req_t dm_in,
	output logic [1:0] psw_bank,
	output logic stk_push,
	output logic stk_pop,
	output logic [7:0] stk_wdata,
	output logic xr_req,
	output logic xr_wr,
	output logic [15:0] xr_addr,
	output logic [7:0] xr_wdata
);
	logic busy_seen;
	logic [9:0] seen;

	// Idle levels from time zero
	initial begin
		{code_req, code_pc, int_ack, int_num, ret_pc, call_req, fl_in, dm_in} = '0;
		{psw_bank, stk_push, stk_pop, stk_wdata, xr_req, xr_wr, xr_addr, xr_wdata} = '0;
		{busy_seen, seen} = '0;
	end

	// Fetch or code-memory read of one address
	task automatic fetch(input logic [15:0] pc);
		@(posedge clk);
		code_req <= 1'b1;
		code_pc <= pc;
		@(posedge clk);
		code_req <= 1'b0;
	endtask : fetch

	// call or interrupt
	// Busy is high for exactly one cycle, so one spare edge keeps the next stack request legal
	task automatic call(input logic irq, input logic [4:0] n, input logic [15:0] ret);
		@(posedge clk);
		call_req <= ~irq;
		int_ack <= irq;
		int_num <= n;
		ret_pc <= ret;
		@(posedge clk);
		call_req <= 1'b0;
		int_ack <= 1'b0;
		#1 busy_seen = busy;
		@(posedge clk);
	endtask : call

	task automatic stk(input logic psh, input logic [7:0] wd);
		@(posedge clk);
		stk_push <= psh;
		stk_pop <= ~psh;
		stk_wdata <= wd;
		@(posedge clk);
		stk_push <= 1'b0;
		stk_pop <= 1'b0;
	endtask : stk

	// Internal data access; the register-space decode is combinational, seen mid-cycle
	task automatic dm(input logic w, input logic ind, input logic bo, input logic bk,
		input logic [7:0] a, input logic [7:0] wd);
		@(posedge clk);
		dm_in <= '{1'b1, w, ind, bo, bk, a, wd};
		#1 seen = {sfr_sel, sfr_ok, sfr_addr};
		@(posedge clk);
		dm_in.req <= 1'b0;
	endtask : dm

	// Auxiliary memory move
	task automatic xr(input logic w, input logic [15:0] a, input logic [7:0] wd);
		@(posedge clk);
		{xr_req, xr_wr, xr_addr, xr_wdata} <= {1'b1, w, a, wd};
		@(posedge clk);
		xr_req <= 1'b0;
	endtask : xr

	// Flash operation request
	task automatic fl(input logic t, input mem_map_pkg::flash_op_t o,
		input mem_map_pkg::flash_region_t r, input logic [14:0] a);
		@(posedge clk);
		fl_in <= '{1'b1, t, o, r, a};
		@(posedge clk);
		fl_in.req <= 1'b0;
	endtask : fl
endmodule : exec_core_model
`default_nettype wire
